/* rtl/pdc_pll_divider_control.sv */
// Register file and divider control for the sampling-clock PLL
`default_nettype none

// Summary of operation
// - Reference divides by code, 3 to 1023
// - Reference divider bypassed unless enable bit set
// - Feedback ratio: low byte plus next nibble
// - Feedback divides oscillator by code, max 4095
// - Codes zero and one pass undivided
// - Feedback ratio resets to 120
// - Feedback pulse goes to phase detector
// - Pump current code drives charge pump
// - PLL enable bit, reset zero
// - Enable register top bit reads zero
// - All ones feedback gives 4095
// - Reference code: low byte plus two bits
// - Timing source select, PLL or external
// - Output divider by code, reset four
module pdc_pll_divider_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [pdc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pdc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pdc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Clock pins
  input wire logic ref_clk_pin,
  input wire logic vco_clk_pin,
  // Analog configuration and divided ticks
  output pdc_pkg::pdc_cfg_s cfg_out,
  output pdc_pkg::pdc_clk_s clk_out
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [pdc_pkg::REG_COUNT-1:0][7:0] regs_reg;
  pdc_pkg::pdc_bus_e bus_state_reg;
  pdc_pkg::pdc_bus_e bus_state_next;
  logic waitrequest_reg;
  logic [pdc_pkg::DATA_W-1:0] readdata_reg;
  logic [pdc_pkg::DATA_W-1:0] readdata_next;
  logic [pdc_pkg::IDX_W-1:0] word_idx;
  logic [pdc_pkg::IDX_W-1:0] reg_sel;
  logic addr_hit;
  logic req_new;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic ref_meta_reg;
  logic ref_sync_reg;
  logic ref_last_reg;
  logic vco_meta_reg;
  logic vco_sync_reg;
  logic vco_last_reg;
  logic ref_edge;
  logic vco_edge;
  logic vco_tick;
  logic conv_pulse_reg;
  logic ref_div_pulse;
  logic fb_pulse;
  logic out_pulse;
  logic [pdc_pkg::REF_W-1:0] ref_code;
  logic [pdc_pkg::REF_W-1:0] ref_ratio_eff;
  logic [pdc_pkg::FB_W-1:0] fb_code;
  logic [pdc_pkg::OUT_W-1:0] out_code;
  logic [7:0] timing_byte;
  logic [7:0] ref_low_byte;
  logic [7:0] out_ref_byte;
  logic [7:0] fb_low_byte;
  logic [7:0] fb_high_byte;
  logic [7:0] pump_byte;
  logic [7:0] enable_byte;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  assign word_idx = avs_address[pdc_pkg::ADDR_W-1:2];
  assign reg_sel = word_idx - pdc_pkg::IDX_FIRST;
  assign addr_hit = (avs_address[1:0] == pdc_pkg::WORD_ALIGN)
                    && (word_idx >= pdc_pkg::IDX_FIRST)
                    && (word_idx <= pdc_pkg::IDX_LAST);
  assign req_new = (avs_read | avs_write) && (bus_state_reg == pdc_pkg::PDC_BUS_IDLE);
  assign wr_fire = avs_write && (bus_state_reg == pdc_pkg::PDC_BUS_ANSWER);
  assign rd_byte = addr_hit ? regs_reg[reg_sel[2:0]] : 8'h00;
  assign readdata_next = avs_read ? {24'h000000, rd_byte} : readdata_reg;

  // ------------------------------------------------------------
  // Handshake: one wait cycle, answer in the second
  // ------------------------------------------------------------
  always_comb begin
    case (bus_state_reg)
      pdc_pkg::PDC_BUS_IDLE: begin
        bus_state_next = req_new ? pdc_pkg::PDC_BUS_ANSWER : pdc_pkg::PDC_BUS_IDLE;
      end
      pdc_pkg::PDC_BUS_ANSWER: begin
        bus_state_next = pdc_pkg::PDC_BUS_IDLE;
      end
      default: begin
        bus_state_next = pdc_pkg::PDC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_state_reg <= pdc_pkg::PDC_BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      bus_state_reg <= bus_state_next;
      waitrequest_reg <= ~req_new;
      if (req_new) begin
        readdata_reg <= readdata_next;
      end
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;

  // ------------------------------------------------------------
  // Register file; factory bits stored, software keeps them
  // ------------------------------------------------------------
  // Writes land on the edge that ends the answer cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regs_reg <= pdc_pkg::REG_RESET;
    end else begin
      for (int i = 0; i < pdc_pkg::REG_COUNT; i++) begin
        if (wr_fire && addr_hit && avs_byteenable[0] && (reg_sel == i[6:0])) begin
          regs_reg[i] <= avs_writedata[7:0] & pdc_pkg::REG_WMASK[i];
        end
      end
    end
  end

  assign timing_byte = regs_reg[pdc_pkg::IDX_TIMING_SRC - pdc_pkg::IDX_FIRST];
  assign ref_low_byte = regs_reg[pdc_pkg::IDX_REF_DIV_LOW - pdc_pkg::IDX_FIRST];
  assign out_ref_byte = regs_reg[pdc_pkg::IDX_OUT_REF_DIV - pdc_pkg::IDX_FIRST];
  assign fb_low_byte = regs_reg[pdc_pkg::IDX_FB_DIV_LOW - pdc_pkg::IDX_FIRST];
  assign fb_high_byte = regs_reg[pdc_pkg::IDX_FB_DIV_HIGH - pdc_pkg::IDX_FIRST];
  assign pump_byte = regs_reg[pdc_pkg::IDX_PUMP_CTRL - pdc_pkg::IDX_FIRST];
  assign enable_byte = regs_reg[pdc_pkg::IDX_ENABLE_CTRL - pdc_pkg::IDX_FIRST];

  // ------------------------------------------------------------
  // Field assembly
  // ------------------------------------------------------------
  assign ref_code = {out_ref_byte[pdc_pkg::REF_HIGH_MSB:0], ref_low_byte};
  assign fb_code = {fb_high_byte[pdc_pkg::FB_HIGH_MSB:0], fb_low_byte};
  assign out_code = out_ref_byte[pdc_pkg::OUTDIV_LSB +: pdc_pkg::OUT_W];
  // Bypass forces ratio one rather than gating the reference
  assign ref_ratio_eff = enable_byte[pdc_pkg::EN_REFDIV_BIT] ? ref_code
                         : pdc_pkg::REF_BYPASS;

  assign cfg_out.pll_on = enable_byte[pdc_pkg::EN_PLL_BIT];
  assign cfg_out.ref_divider_on = enable_byte[pdc_pkg::EN_REFDIV_BIT];
  assign cfg_out.bias_self = pump_byte[pdc_pkg::BIAS_BIT];
  assign cfg_out.timing_src_pll = timing_byte[pdc_pkg::TSRC_BIT];
  assign cfg_out.pump_current_code = pump_byte[pdc_pkg::PUMP_MSB:0];
  assign cfg_out.ref_divider_ratio = ref_code;
  assign cfg_out.feedback_ratio = fb_code;
  assign cfg_out.output_divider_ratio = out_code;

  // ------------------------------------------------------------
  // Clock pin synchronisers and edge detect
  // ------------------------------------------------------------
  // Pin clocks are far slower than core_clk in this model
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_last_reg <= 1'b0;
      vco_meta_reg <= 1'b0;
      vco_sync_reg <= 1'b0;
      vco_last_reg <= 1'b0;
    end else begin
      ref_meta_reg <= ref_clk_pin;
      ref_sync_reg <= ref_meta_reg;
      ref_last_reg <= ref_sync_reg;
      vco_meta_reg <= vco_clk_pin;
      vco_sync_reg <= vco_meta_reg;
      vco_last_reg <= vco_sync_reg;
    end
  end

  assign ref_edge = ref_sync_reg & ~ref_last_reg;
  assign vco_edge = vco_sync_reg & ~vco_last_reg;
  // Oscillator side counts only while the PLL runs
  assign vco_tick = vco_edge & cfg_out.pll_on;

  // ------------------------------------------------------------
  // Dividers
  // ------------------------------------------------------------
  pdc_divider #(
    .W(pdc_pkg::REF_W),
    .RESET_RATIO(pdc_pkg::REF_RESET_RATIO)
  ) u_ref_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick_in(ref_edge),
    .ratio(ref_ratio_eff),
    .pulse_out(ref_div_pulse)
  );

  pdc_divider #(
    .W(pdc_pkg::FB_W),
    .RESET_RATIO(pdc_pkg::FB_RESET_RATIO)
  ) u_fb_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick_in(vco_tick),
    .ratio(fb_code),
    .pulse_out(fb_pulse)
  );

  pdc_divider #(
    .W(pdc_pkg::OUT_W),
    .RESET_RATIO(pdc_pkg::OUT_RESET_RATIO)
  ) u_out_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick_in(vco_tick),
    .ratio(out_code),
    .pulse_out(out_pulse)
  );

  // ------------------------------------------------------------
  // Timing source select
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_pulse_reg <= 1'b0;
    end else begin
      conv_pulse_reg <= cfg_out.timing_src_pll ? out_pulse : ref_edge;
    end
  end

  assign clk_out.ref_div_pulse = ref_div_pulse;
  assign clk_out.feedback_pulse = fb_pulse;
  assign clk_out.output_pulse = out_pulse;
  assign clk_out.conv_pulse = conv_pulse_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic fb_touched_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fb_touched_reg <= 1'b0;
    end else if (wr_fire && addr_hit && (word_idx == pdc_pkg::IDX_FB_DIV_LOW
                 || word_idx == pdc_pkg::IDX_FB_DIV_HIGH)) begin
      fb_touched_reg <= 1'b1;
    end
  end

  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (
    s_request |=> s_answer)
    else $error("bus answer not after one wait cycle");

  a_enable_top_zero: assert property (
    avs_read && !avs_waitrequest && addr_hit
    && (word_idx == pdc_pkg::IDX_ENABLE_CTRL) |-> !avs_readdata[pdc_pkg::EN_UNUSED_BIT])
    else $error("enable register top bit read as one");

  a_fb_default: assert property (
    !fb_touched_reg |-> (cfg_out.feedback_ratio == pdc_pkg::FB_RESET_RATIO))
    else $error("feedback ratio not 120 after reset");

  a_fb_write_lands: assert property (
    wr_fire && addr_hit && avs_byteenable[0] && (word_idx == pdc_pkg::IDX_FB_DIV_HIGH)
    |=> cfg_out.feedback_ratio[11:8] == $past(avs_writedata[3:0]))
    else $error("feedback upper nibble not written");

  a_ref_bypass: assert property (
    !cfg_out.ref_divider_on |-> (ref_ratio_eff == pdc_pkg::REF_BYPASS))
    else $error("reference divider not bypassed");

  a_pll_off_quiet: assert property (
    !cfg_out.pll_on && !$past(cfg_out.pll_on) |-> !fb_pulse && !out_pulse)
    else $error("feedback pulse while PLL is off");

  a_src_select: assert property (
    cfg_out.timing_src_pll && out_pulse |=> clk_out.conv_pulse)
    else $error("PLL source not routed to converter");

  a_pump_code: assert property (
    wr_fire && addr_hit && avs_byteenable[0] && (word_idx == pdc_pkg::IDX_PUMP_CTRL)
    |=> cfg_out.pump_current_code == $past(avs_writedata[3:0]))
    else $error("pump current code not written");

  // Each field write lands one edge after the bus accepts it
  a_pll_on_write: assert property (
    wr_fire && addr_hit && avs_byteenable[0] && (word_idx == pdc_pkg::IDX_ENABLE_CTRL)
    |=> cfg_out.pll_on == $past(avs_writedata[pdc_pkg::EN_PLL_BIT]))
    else $error("PLL enable bit not written");

  a_ref_low_write: assert property (
    wr_fire && addr_hit && avs_byteenable[0] && (word_idx == pdc_pkg::IDX_REF_DIV_LOW)
    |=> cfg_out.ref_divider_ratio[7:0] == $past(avs_writedata[7:0]))
    else $error("reference code low byte not written");

  a_fb_low_write: assert property (
    wr_fire && addr_hit && avs_byteenable[0] && (word_idx == pdc_pkg::IDX_FB_DIV_LOW)
    |=> cfg_out.feedback_ratio[7:0] == $past(avs_writedata[7:0]))
    else $error("feedback low byte not written");

  a_out_code_write: assert property (
    wr_fire && addr_hit && avs_byteenable[0] && (word_idx == pdc_pkg::IDX_OUT_REF_DIV)
    |=> cfg_out.output_divider_ratio
        == $past(avs_writedata[pdc_pkg::OUTDIV_LSB +: pdc_pkg::OUT_W]))
    else $error("output divider code not written");

  // External source is the default, so this one fires from reset on
  a_conv_external: assert property (
    !cfg_out.timing_src_pll && ref_edge |=> clk_out.conv_pulse)
    else $error("external source not routed to converter");

  a_top_bit_store: assert property (
    !enable_byte[pdc_pkg::EN_UNUSED_BIT])
    else $error("enable register top bit stored as one");

endmodule : pdc_pll_divider_control

`default_nettype wire

/* rtl/pdc_pkg.sv */
// Package: register map, field layout and carriers of the PLL divider control
`default_nettype none

package pdc_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int IDX_W = 7;
  localparam int REG_COUNT = 7;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TIMING_SRC = 7'h53;
  localparam logic [IDX_W-1:0] IDX_REF_DIV_LOW = 7'h54;
  localparam logic [IDX_W-1:0] IDX_OUT_REF_DIV = 7'h55;
  localparam logic [IDX_W-1:0] IDX_FB_DIV_LOW = 7'h56;
  localparam logic [IDX_W-1:0] IDX_FB_DIV_HIGH = 7'h57;
  localparam logic [IDX_W-1:0] IDX_PUMP_CTRL = 7'h58;
  localparam logic [IDX_W-1:0] IDX_ENABLE_CTRL = 7'h59;
  localparam logic [IDX_W-1:0] IDX_FIRST = IDX_TIMING_SRC;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_ENABLE_CTRL;

  // ------------------------------------------------------------
  // Reset values, element n belongs to index IDX_FIRST + n
  // ------------------------------------------------------------
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h41, 8'h12, 8'h40, 8'h78, 8'h48, 8'h00, 8'h00
  };
  // Writable bits; the enable register top bit is not implemented
  localparam logic [REG_COUNT-1:0][7:0] REG_WMASK = {
    8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
  };

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TSRC_BIT = 4;
  localparam int REF_HIGH_MSB = 1;
  localparam int OUTDIV_LSB = 4;
  localparam int FB_HIGH_MSB = 3;
  localparam int PUMP_MSB = 3;
  localparam int BIAS_BIT = 4;
  localparam int EN_REFDIV_BIT = 4;
  localparam int EN_PLL_BIT = 1;
  localparam int EN_UNUSED_BIT = 7;

  // ------------------------------------------------------------
  // Divider widths and ratios
  // ------------------------------------------------------------
  localparam int REF_W = 10;
  localparam int FB_W = 12;
  localparam int OUT_W = 4;
  localparam logic [REF_W-1:0] REF_RESET_RATIO = 10'h001;
  localparam logic [FB_W-1:0] FB_RESET_RATIO = 12'h078;
  localparam logic [OUT_W-1:0] OUT_RESET_RATIO = 4'h4;
  localparam logic [REF_W-1:0] REF_BYPASS = 10'h000;

  // ------------------------------------------------------------
  // Bus handshake states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PDC_BUS_IDLE = 2'b01,
    PDC_BUS_ANSWER = 2'b10
  } pdc_bus_e;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic pll_on;
    logic ref_divider_on;
    logic bias_self;
    logic timing_src_pll;
    logic [3:0] pump_current_code;
    logic [REF_W-1:0] ref_divider_ratio;
    logic [FB_W-1:0] feedback_ratio;
    logic [OUT_W-1:0] output_divider_ratio;
  } pdc_cfg_s;

  typedef struct packed {
    logic ref_div_pulse;
    logic feedback_pulse;
    logic output_pulse;
    logic conv_pulse;
  } pdc_clk_s;

endpackage : pdc_pkg

`default_nettype wire

/* rtl/pdc_divider.sv */
// Pulse divider with terminal-count ratio reload
`default_nettype none

module pdc_divider #(
  parameter int W = 12,
  parameter logic [W-1:0] RESET_RATIO = W'(1)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Input ticks and ratio code
  input wire logic tick_in,
  input wire logic [W-1:0] ratio,
  // Divided tick
  output logic pulse_out
);

  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] active_reg;
  logic [W-1:0] ratio_eff;
  logic terminal;

  // ------------------------------------------------------------
  // Ratio decode, zero and one both pass undivided
  // ------------------------------------------------------------
  assign ratio_eff = (ratio == '0) ? ONE : ratio;
  assign terminal = (cnt_reg == active_reg - ONE);
  assign cnt_next = terminal ? '0 : cnt_reg + ONE;

  // ------------------------------------------------------------
  // Counter; new ratio only at terminal count, no runt pulse
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      active_reg <= RESET_RATIO;
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= tick_in & terminal;
      if (tick_in) begin
        cnt_reg <= cnt_next;
      end
      if (tick_in & terminal) begin
        active_reg <= ratio_eff;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ratio_reload: assert property (
    !$stable(active_reg) |-> $past(tick_in & terminal))
    else $error("divider ratio changed away from terminal count");

  a_count_bound: assert property (
    cnt_reg < active_reg)
    else $error("divider count passed its ratio");

  a_unity_pass: assert property (
    (active_reg == ONE) && tick_in |=> pulse_out)
    else $error("ratio one did not pass tick");

endmodule : pdc_divider

`default_nettype wire

/* dv/test_pdc_pll_divider_control.sv */
// Self-checking testbench of the PLL divider control block
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_pdc_pll_divider_control;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [pdc_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [pdc_pkg::DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [pdc_pkg::DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic ref_clk_pin = 1'b0;
  logic vco_clk_pin = 1'b0;
  pdc_pkg::pdc_cfg_s cfg_out;
  pdc_pkg::pdc_clk_s clk_out;
  wire logic [3:0] pulses = {clk_out.conv_pulse, clk_out.output_pulse,
                             clk_out.feedback_pulse, clk_out.ref_div_pulse};
  int bad_count = 0;
  int compares = 0;
  // Shadow of indices 0x53..0x59 and the bits software may change
  logic [7:0] sh [7] = '{8'h00, 8'h00, 8'h48, 8'h78, 8'h40, 8'h12, 8'h41};
  logic [7:0] user_mask [7] = '{8'h10, 8'hFF, 8'hF3, 8'hFF, 8'h0F, 8'h1F, 8'h12};

  pdc_pll_divider_control dut_u (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_clk_pin(ref_clk_pin), .vco_clk_pin(vco_clk_pin), .cfg_out(cfg_out),
    .clk_out(clk_out)
  );

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------
  function automatic pdc_pkg::pdc_cfg_s exp_cfg();
    pdc_pkg::pdc_cfg_s c;
    c.pll_on = sh[6][1];
    c.ref_divider_on = sh[6][4];
    c.bias_self = sh[5][4];
    c.timing_src_pll = sh[0][4];
    c.pump_current_code = sh[5][3:0];
    c.ref_divider_ratio = {sh[2][1:0], sh[1]};
    c.feedback_ratio = {sh[4][3:0], sh[3]};
    c.output_divider_ratio = sh[2][7:4];
    return c;
  endfunction : exp_cfg

  function automatic int eff(input int code);
    return (code < 2) ? 1 : code;
  endfunction : eff

  function automatic logic [8:0] addr_of(input int i);
    return 9'((32'h53 + i) << 2);
  endfunction : addr_of

  // ------------------------------------------------------------
  // Bus and pin drivers
  // ------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // Request held until waitrequest is sampled low; one idle edge after it
  task automatic bus_xfer(input logic we, input logic [8:0] addr, input logic [7:0] wd,
                          input logic [3:0] be, output logic [31:0] rdata);
    int n;
    n = 0;
    avs_address <= addr;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      summarize();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus_xfer

  task automatic wr(input int i, input logic [7:0] d);
    logic [31:0] r;
    bus_xfer(1'b1, addr_of(i), d, 4'hF, r);
    sh[i] = (i == 6) ? (d & 8'h7F) : d;
    `CHK(cfg_out, exp_cfg())
  endtask : wr

  task automatic rd(input int i);
    logic [31:0] r;
    bus_xfer(1'b0, addr_of(i), 8'h00, 4'hF, r);
    `CHK(r, {24'h000000, sh[i]})
  endtask : rd

  // Pin toggles three cycles high, three low; records spacing of pulses in ticks
  task automatic run_ticks(input int sel, input int n, output int cnt, output int gap);
    int last;
    cnt = 0;
    gap = 0;
    last = -1;
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < 6; c++) begin
        @(posedge core_clk);
        // Seen as sampled at this edge; the pin then moves by NBA
        if (pulses[sel] === 1'b1) begin
          cnt++;
          if (last >= 0) gap = i - last;
          last = i;
        end
        if (sel == 0) begin
          ref_clk_pin <= (c < 3);
        end else begin
          vco_clk_pin <= (c < 3);
        end
      end
    end
  endtask : run_ticks

  // Flush covers the old period, which must finish before a new ratio loads
  task automatic check_div(input int sel, input int r, input int flush);
    int cnt;
    int gap;
    run_ticks(sel, flush + 2 * r + 6, cnt, gap);
    `CHK(gap, r)
  endtask : check_div

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    int cnt;
    int gap;
    int code;
    logic [31:0] r;
    logic [7:0] v;
    void'($urandom(32'h9375));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 7; i++) rd(i);
    `CHK(cfg_out, exp_cfg())
    run_ticks(1, 12, cnt, gap);
    `CHK(cnt, 0)
    run_ticks(2, 12, cnt, gap);
    `CHK(cnt, 0)
    check_div(0, 1, 1);
    wr(6, 8'h43);
    check_div(1, 120, 120);
    check_div(2, 4, 4);
    code = 120;
    foreach (sh[k]) begin
      if (k < 5) begin
        wr(3, 8'(k == 0 ? 2 : k == 4 ? 7 : k - 1));
        check_div(1, eff(sh[3]), code);
        code = eff(sh[3]);
      end
    end
    foreach (sh[k]) begin
      if (k < 3) begin
        wr(2, {4'(k == 2 ? 3 : k), 4'h8});
        check_div(2, eff(sh[2][7:4]), 4);
      end
    end
    wr(0, 8'h10);
    check_div(3, 3, 3);
    wr(1, 8'h05);
    check_div(0, 1, 1);
    wr(6, 8'h53);
    check_div(0, 5, 1);
    wr(1, 8'h03);
    check_div(0, 3, 5);
    wr(1, 8'(3 + $urandom_range(37)));
    check_div(0, int'(sh[1]), 3);
    wr(2, 8'h4B);
    wr(4, 8'h4F);
    wr(3, 8'hFF);
    wr(2, 8'h48);
    check_div(1, 4095, 7);
    bus_xfer(1'b0, 9'h000, 8'h00, 4'hF, r);
    `CHK(r, 32'h00000000)
    bus_xfer(1'b1, addr_of(-1), 8'hA5, 4'hF, r);
    bus_xfer(1'b0, addr_of(-1), 8'h00, 4'hF, r);
    `CHK(r, 32'h00000000)
    bus_xfer(1'b1, addr_of(3) + 9'h001, 8'h11, 4'hF, r);
    bus_xfer(1'b1, addr_of(5), 8'h1F, 4'h0, r);
    rd(3);
    rd(5);
    wr(5, 8'h1F);
    wr(6, 8'hC3);
    rd(6);
    repeat (40) begin
      code = $urandom_range(6);
      v = (8'($urandom) & user_mask[code]) | (sh[code] & ~user_mask[code]);
      // Reference code two is unsupported; software steers around it
      if (code == 1 && v == 8'h02) begin
        v = 8'h03;
      end
      wr(code, v);
      rd(code);
    end
    summarize();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    summarize();
  end

endmodule : test_pdc_pll_divider_control

`undef CHK
`default_nettype wire
